// ### design/bp_pkg.sv
// Constants and types shared by the branch prediction and resolution block
package bp_pkg;
	localparam int ADDR_W = 32;
	localparam int LEN_W = 4;
	localparam int BHT_ENTRIES = 8192;
	localparam int BHT_IDX_W = 13;
	localparam int CTR_W = 2;
	localparam logic [CTR_W-1:0] CTR_INIT = 2'h1;
	localparam logic [CTR_W-1:0] CTR_MAX = 2'h3;
	localparam logic [CTR_W-1:0] CTR_MIN = 2'h0;
	localparam logic [BHT_IDX_W-1:0] BHT_LAST = 13'h1FFF;
	localparam int LINE_BYTES = 16;
	localparam int LINE_W = LINE_BYTES * 8;
	localparam int OFS_W = 4;
	localparam int TAG_W = ADDR_W - OFS_W;
	localparam int BTC_ENTRIES = 16;
	localparam int BTC_IDX_W = 4;
	localparam int RAS_DEPTH = 16;
	localparam int RAS_PTR_W = 4;
	localparam int RAS_CNT_W = 5;
	localparam logic [RAS_CNT_W-1:0] RAS_FULL = 5'h10;
	localparam int SLOT_NUM = 8;
	localparam int SLOT_W = 3;
	localparam logic [SLOT_W-1:0] MAX_OUTSTANDING = 3'h7;
	localparam int CAND_NUM = 2;
	localparam int CAND_SEL_W = 1;
	typedef enum logic [2:0] {
		KIND_NONE = 3'h0,
		KIND_JUMP = 3'h1,
		KIND_COND = 3'h2,
		KIND_CALL = 3'h3,
		KIND_RET = 3'h4
	} br_kind_t;
	typedef enum logic [0:0] {
		ST_INIT = 1'h0,
		ST_RUN = 1'h1
	} bp_state_t;
endpackage

// ### design/bp_return_stack.sv
// Circular return address stack that overwrites its oldest entry when full
`timescale 1ns/1ps
module bp_return_stack
	import bp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Stack requests
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [ADDR_W-1:0] push_addr_i,
	// Top of stack
	output logic [ADDR_W-1:0] top_addr_o,
	output logic top_vld_o
);
	logic [ADDR_W-1:0] stack_mem [RAS_DEPTH];
	logic [RAS_PTR_W-1:0] top_ptr_ff;
	logic [RAS_PTR_W-1:0] nxt_top_ptr;
	logic [RAS_CNT_W-1:0] cnt_ff;
	logic [RAS_CNT_W-1:0] nxt_cnt;

	// Pointer wraps, so a push on a full stack lands on the oldest slot
	always_comb begin
		nxt_top_ptr = top_ptr_ff;
		nxt_cnt = cnt_ff;
		if (push_i) begin
			nxt_top_ptr = top_ptr_ff + 4'h1;
			if (cnt_ff != RAS_FULL) begin
				nxt_cnt = cnt_ff + 5'h01;
			end
		end else if (pop_i && cnt_ff != 5'h00) begin
			nxt_top_ptr = top_ptr_ff - 4'h1;
			nxt_cnt = cnt_ff - 5'h01;
		end
	end

	// Pointer and depth registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			top_ptr_ff <= 4'h0;
			cnt_ff <= 5'h00;
		end else begin
			top_ptr_ff <= nxt_top_ptr;
			cnt_ff <= nxt_cnt;
		end
	end

	// Storage, no reset needed since depth gates validity
	always_ff @(posedge core_clk_i) begin
		if (push_i) begin
			stack_mem[nxt_top_ptr] <= push_addr_i;
		end
	end

	assign top_addr_o = stack_mem[top_ptr_ff];
	assign top_vld_o = (cnt_ff != 5'h00);
endmodule

// ### design/branch_prediction_resolution.sv
// Branch predictor, target cache, return stack and speculation tracker
`timescale 1ns/1ps
module branch_prediction_resolution
	import bp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Decoder branch report
	input wire logic dec_valid_i,
	input wire br_kind_t dec_kind_i,
	input wire logic [ADDR_W-1:0] dec_pc_i,
	input wire logic [LEN_W-1:0] dec_len_i,
	input wire logic [ADDR_W-1:0] dec_disp0_i,
	input wire logic [ADDR_W-1:0] dec_disp1_i,
	input wire logic [CAND_SEL_W-1:0] dec_sel_i,
	// Target cache fill from the instruction cache
	input wire logic btc_fill_i,
	input wire logic [ADDR_W-1:0] btc_fill_addr_i,
	input wire logic [LINE_W-1:0] btc_fill_data_i,
	// Branch condition unit result
	input wire logic res_valid_i,
	input wire logic [SLOT_W-1:0] res_tag_i,
	input wire logic res_taken_i,
	// Fetch steering
	output logic fetch_redirect_o,
	output logic [ADDR_W-1:0] fetch_target_o,
	output logic ibuf_flush_o,
	output logic ibuf_load_o,
	output logic [LINE_W-1:0] ibuf_data_o,
	output logic branch_stall_o,
	// Speculation status to the scheduler
	output logic branch_tag_vld_o,
	output logic [SLOT_W-1:0] branch_tag_o,
	output logic pred_taken_o,
	output logic mispredict_o,
	output logic [SLOT_W-1:0] recover_tag_o,
	output logic spec_pending_o
);
	// History table and speculation slots
	logic [CTR_W-1:0] bht_mem [BHT_ENTRIES];
	logic [BHT_IDX_W-1:0] ghr_ff, nxt_ghr;
	bp_state_t state_ff, nxt_state;
	logic [BHT_IDX_W-1:0] init_idx_ff, nxt_init_idx;
	logic bht_we;
	logic [BHT_IDX_W-1:0] bht_waddr;
	logic [CTR_W-1:0] bht_wdata;
	logic [SLOT_NUM-1:0] slot_vld_ff, nxt_slot_vld;
	logic [SLOT_NUM-1:0] slot_done_ff, nxt_slot_done;
	logic slot_pred_ff [SLOT_NUM];
	logic [ADDR_W-1:0] slot_alt_ff [SLOT_NUM];
	logic [BHT_IDX_W-1:0] slot_idx_ff [SLOT_NUM];
	logic [BHT_IDX_W-1:0] slot_ghr_ff [SLOT_NUM];
	logic [SLOT_W-1:0] head_ff, nxt_head, tail_ff, nxt_tail;
	logic alloc;
	// Target cache
	logic [TAG_W-1:0] btc_tag_ff [BTC_ENTRIES];
	logic [LINE_W-1:0] btc_data_ff [BTC_ENTRIES];
	logic [BTC_ENTRIES-1:0] btc_vld_ff, nxt_btc_vld;
	logic [BTC_IDX_W-1:0] btc_victim_ff, nxt_btc_victim;
	// Decode datapath
	logic [ADDR_W-1:0] fallthru;
	logic [ADDR_W-1:0] cand [CAND_NUM];
	logic [ADDR_W-1:0] dec_target;
	logic [BHT_IDX_W-1:0] dec_idx;
	logic dec_pred;
	logic accept;
	logic ras_push, ras_pop, ras_vld;
	logic [ADDR_W-1:0] ras_top;
	logic mis_now;
	logic [SLOT_W-1:0] live_span;
	// Output next values
	logic nxt_redirect, nxt_flush, nxt_load, nxt_stall;
	logic nxt_tag_vld, nxt_pred, nxt_mis;
	logic [ADDR_W-1:0] nxt_target;
	logic [LINE_W-1:0] nxt_data;
	logic [SLOT_W-1:0] nxt_tag, nxt_rtag;
	logic [SLOT_NUM-1:0] kill;
	logic btc_hit;
	logic [LINE_W-1:0] btc_line;

	// Saturating two-bit counter step toward the actual outcome
	function automatic logic [CTR_W-1:0] ctr_step(input logic [CTR_W-1:0] c, input logic up);
		logic [CTR_W-1:0] r;
		r = c;
		if (up && c != CTR_MAX) begin
			r = c + 2'h1;
		end else if (!up && c != CTR_MIN) begin
			r = c - 2'h1;
		end
		return r;
	endfunction

	// Any kind that moves fetch away from the sequential path
	function automatic logic is_transfer(input br_kind_t k, input logic pred, input logic rvld);
		return (k == KIND_JUMP) || (k == KIND_CALL) || (k == KIND_COND && pred) || (k == KIND_RET && rvld);
	endfunction

	// Candidate target adders run in parallel with decode
	assign fallthru = dec_pc_i + {{(ADDR_W-LEN_W){1'b0}}, dec_len_i};
	assign cand[0] = fallthru + dec_disp0_i;
	assign cand[1] = fallthru + dec_disp1_i;
	assign dec_target = cand[dec_sel_i];

	// Global history hashed with the address picks a counter
	assign dec_idx = dec_pc_i[BHT_IDX_W-1:0] ^ ghr_ff;
	assign dec_pred = bht_mem[dec_idx][CTR_W-1];

	// Resolution of a live slot whose outcome differs from its guess
	assign mis_now = res_valid_i && slot_vld_ff[res_tag_i] && !slot_done_ff[res_tag_i]
		&& (slot_pred_ff[res_tag_i] != res_taken_i);
	assign live_span = tail_ff - res_tag_i;

	// A younger decode is dropped when the same cycle reports a misprediction
	assign accept = dec_valid_i && (state_ff == ST_RUN) && !mis_now
		&& !(dec_kind_i == KIND_COND && (tail_ff - head_ff) == MAX_OUTSTANDING);
	assign alloc = accept && (dec_kind_i == KIND_COND);
	assign ras_push = accept && (dec_kind_i == KIND_CALL);
	assign ras_pop = accept && (dec_kind_i == KIND_RET);

	bp_return_stack u_ras (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.push_i(ras_push),
		.pop_i(ras_pop),
		.push_addr_i(fallthru),
		.top_addr_o(ras_top),
		.top_vld_o(ras_vld)
	);

	// Fully associative target cache lookup on the chosen target
	always_comb begin
		btc_hit = 1'b0;
		btc_line = '0;
		for (int i = 0; i < BTC_ENTRIES; i++) begin
			if (btc_vld_ff[i] && btc_tag_ff[i] == nxt_target[ADDR_W-1:OFS_W]) begin
				btc_hit = 1'b1;
				btc_line = btc_data_ff[i];
			end
		end
	end

	// Round-robin replacement keeps the fill path simple
	always_comb begin
		nxt_btc_vld = btc_vld_ff;
		nxt_btc_victim = btc_victim_ff;
		if (btc_fill_i) begin
			nxt_btc_vld[btc_victim_ff] = 1'b1;
			nxt_btc_victim = btc_victim_ff + 4'h1;
		end
	end

	// History table writer: reset sweep first, then resolved outcomes
	always_comb begin
		nxt_state = state_ff;
		nxt_init_idx = init_idx_ff;
		bht_we = 1'b0;
		bht_waddr = init_idx_ff;
		bht_wdata = CTR_INIT;
		case (state_ff)
			ST_INIT: begin
				bht_we = 1'b1;
				nxt_init_idx = init_idx_ff + 13'h0001;
				if (init_idx_ff == BHT_LAST) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (res_valid_i && slot_vld_ff[res_tag_i] && !slot_done_ff[res_tag_i]) begin
					bht_we = 1'b1;
					bht_waddr = slot_idx_ff[res_tag_i];
					bht_wdata = ctr_step(bht_mem[slot_idx_ff[res_tag_i]], res_taken_i);
				end
			end
			default: begin
				nxt_state = ST_INIT;
			end
		endcase
	end

	// Speculation tracker and fetch steering
	always_comb begin
		nxt_slot_vld = slot_vld_ff;
		nxt_slot_done = slot_done_ff;
		nxt_head = head_ff;
		nxt_tail = tail_ff;
		nxt_ghr = ghr_ff;
		nxt_redirect = 1'b0;
		nxt_target = fetch_target_o;
		nxt_tag_vld = 1'b0;
		nxt_tag = branch_tag_o;
		nxt_pred = 1'b0;
		nxt_mis = 1'b0;
		nxt_rtag = recover_tag_o;
		kill = '0;
		// Oldest resolved slot retires, freeing its entry
		if (slot_vld_ff[head_ff] && slot_done_ff[head_ff]) begin
			nxt_slot_vld[head_ff] = 1'b0;
			nxt_head = head_ff + 3'h1;
		end
		if (res_valid_i && slot_vld_ff[res_tag_i]) begin
			nxt_slot_done[res_tag_i] = 1'b1;
		end
		if (mis_now) begin
			// Drop every younger slot and rewind history to this branch
			for (int i = 0; i < SLOT_NUM; i++) begin
				if (3'(i - int'(res_tag_i)) != 3'h0 && 3'(i - int'(res_tag_i)) < live_span) begin
					kill[i] = 1'b1;
				end
			end
			nxt_slot_vld = nxt_slot_vld & ~kill;
			nxt_tail = res_tag_i + 3'h1;
			nxt_ghr = {slot_ghr_ff[res_tag_i][BHT_IDX_W-2:0], res_taken_i};
			nxt_redirect = 1'b1;
			nxt_target = slot_alt_ff[res_tag_i];
			nxt_mis = 1'b1;
			nxt_rtag = res_tag_i;
		end else if (accept) begin
			case (dec_kind_i)
				KIND_JUMP, KIND_CALL: begin
					nxt_redirect = is_transfer(dec_kind_i, dec_pred, ras_vld);
					nxt_target = dec_target;
				end
				KIND_RET: begin
					nxt_redirect = is_transfer(dec_kind_i, dec_pred, ras_vld);
					nxt_target = ras_vld ? ras_top : fetch_target_o;
				end
				KIND_COND: begin
					// Issue continues past the branch while it is unresolved
					nxt_slot_vld[tail_ff] = 1'b1;
					nxt_slot_done[tail_ff] = 1'b0;
					nxt_tail = tail_ff + 3'h1;
					nxt_ghr = {ghr_ff[BHT_IDX_W-2:0], dec_pred};
					nxt_redirect = is_transfer(dec_kind_i, dec_pred, ras_vld);
					nxt_target = dec_pred ? dec_target : fetch_target_o;
					nxt_tag_vld = 1'b1;
					nxt_tag = tail_ff;
					nxt_pred = dec_pred;
				end
				default: begin
					nxt_redirect = 1'b0;
				end
			endcase
		end
		// Transfers always flush; a cache hit also loads the first line
		nxt_flush = nxt_redirect;
		nxt_load = nxt_redirect && btc_hit;
		nxt_data = nxt_load ? btc_line : ibuf_data_o; // Data only moves with a load
		nxt_stall = (nxt_state == ST_INIT) || ((nxt_tail - nxt_head) == MAX_OUTSTANDING);
	end

	// Control registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_ff <= ST_INIT;
			init_idx_ff <= '0;
			ghr_ff <= '0;
			slot_vld_ff <= '0;
			slot_done_ff <= '0;
			head_ff <= '0;
			tail_ff <= '0;
			btc_vld_ff <= '0;
			btc_victim_ff <= '0;
			fetch_redirect_o <= 1'b0;
			fetch_target_o <= '0;
			ibuf_flush_o <= 1'b0;
			ibuf_load_o <= 1'b0;
			ibuf_data_o <= '0;
			branch_stall_o <= 1'b1;
			branch_tag_vld_o <= 1'b0;
			branch_tag_o <= '0;
			pred_taken_o <= 1'b0;
			mispredict_o <= 1'b0;
			recover_tag_o <= '0;
			spec_pending_o <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			init_idx_ff <= nxt_init_idx;
			ghr_ff <= nxt_ghr;
			slot_vld_ff <= nxt_slot_vld;
			slot_done_ff <= nxt_slot_done;
			head_ff <= nxt_head;
			tail_ff <= nxt_tail;
			btc_vld_ff <= nxt_btc_vld;
			btc_victim_ff <= nxt_btc_victim;
			fetch_redirect_o <= nxt_redirect;
			fetch_target_o <= nxt_target;
			ibuf_flush_o <= nxt_flush;
			ibuf_load_o <= nxt_load;
			ibuf_data_o <= nxt_data;
			branch_stall_o <= nxt_stall;
			branch_tag_vld_o <= nxt_tag_vld;
			branch_tag_o <= nxt_tag;
			pred_taken_o <= nxt_pred;
			mispredict_o <= nxt_mis;
			recover_tag_o <= nxt_rtag;
			spec_pending_o <= (nxt_slot_vld != '0);
		end
	end

	// Arrays without reset; validity bits above guard the slot and cache arrays, the reset sweep fills the history table
	always_ff @(posedge core_clk_i) begin
		if (bht_we) begin
			bht_mem[bht_waddr] <= bht_wdata;
		end
		if (alloc) begin
			slot_pred_ff[tail_ff] <= dec_pred;
			slot_alt_ff[tail_ff] <= dec_pred ? fallthru : dec_target;
			slot_idx_ff[tail_ff] <= dec_idx;
			slot_ghr_ff[tail_ff] <= ghr_ff;
		end
		if (btc_fill_i) begin
			btc_tag_ff[btc_victim_ff] <= btc_fill_addr_i[ADDR_W-1:OFS_W];
			btc_data_ff[btc_victim_ff] <= btc_fill_data_i;
		end
	end
endmodule

// ### verif/bp_check_sva.sv
// Port-level assertions for the branch prediction and resolution block
`timescale 1ns/1ps
module bp_check_sva
	import bp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Decoder and resolve inputs
	input wire logic dec_valid_i,
	input wire br_kind_t dec_kind_i,
	input wire logic [ADDR_W-1:0] dec_pc_i,
	input wire logic [LEN_W-1:0] dec_len_i,
	input wire logic [ADDR_W-1:0] dec_disp0_i,
	input wire logic [ADDR_W-1:0] dec_disp1_i,
	input wire logic [CAND_SEL_W-1:0] dec_sel_i,
	input wire logic res_valid_i,
	// Block outputs
	input wire logic fetch_redirect_o,
	input wire logic [ADDR_W-1:0] fetch_target_o,
	input wire logic ibuf_flush_o,
	input wire logic ibuf_load_o,
	input wire logic branch_stall_o,
	input wire logic branch_tag_vld_o,
	input wire logic pred_taken_o,
	input wire logic mispredict_o,
	input wire logic spec_pending_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	logic [ADDR_W-1:0] jmp_tgt;
	logic take_ok;
	// Expected target; a resolve in the same cycle may drop the decode, so it is excluded
	always_comb begin
		jmp_tgt = dec_pc_i + {{(ADDR_W-LEN_W){1'b0}}, dec_len_i} + (dec_sel_i[0] ? dec_disp1_i : dec_disp0_i);
	end
	assign take_ok = dec_valid_i && !branch_stall_o && !res_valid_i;
	jump_target_a: assert property (take_ok && dec_kind_i == KIND_JUMP |=>
		fetch_redirect_o && fetch_target_o == $past(jmp_tgt)) else $error("jump target wrong");
	flush_match_a: assert property (ibuf_flush_o == fetch_redirect_o) else $error("flush mismatch");
	load_redir_a: assert property (ibuf_load_o |-> fetch_redirect_o) else $error("load without redirect");
	cond_refused_a: assert property (dec_valid_i && dec_kind_i == KIND_COND && branch_stall_o
		|=> !branch_tag_vld_o) else $error("branch taken while stalled");
	cond_tag_a: assert property (take_ok && dec_kind_i == KIND_COND |=> branch_tag_vld_o)
		else $error("branch not tracked");
	not_taken_a: assert property (branch_tag_vld_o && !pred_taken_o |-> !fetch_redirect_o)
		else $error("redirect on not taken");
	taken_redir_a: assert property (branch_tag_vld_o && pred_taken_o |-> fetch_redirect_o)
		else $error("no redirect on taken");
	mispredict_redir_a: assert property (mispredict_o |-> fetch_redirect_o && $past(res_valid_i))
		else $error("bad recovery");
	pending_hold_a: assert property (branch_tag_vld_o |-> spec_pending_o) else $error("pending low");
	jump_c: cover property (take_ok && dec_kind_i == KIND_JUMP ##1 fetch_redirect_o);
	load_c: cover property (ibuf_load_o);
	mispredict_c: cover property (mispredict_o);
	full_c: cover property (branch_stall_o && spec_pending_o);
	taken_c: cover property (branch_tag_vld_o && pred_taken_o);
endmodule
bind branch_prediction_resolution bp_check_sva u_bp_check_sva (.core_clk_i, .srst_i, .dec_valid_i, .dec_kind_i,
	.dec_pc_i, .dec_len_i, .dec_disp0_i, .dec_disp1_i, .dec_sel_i, .res_valid_i, .fetch_redirect_o, .fetch_target_o,
	.ibuf_flush_o, .ibuf_load_o, .branch_stall_o, .branch_tag_vld_o, .pred_taken_o, .mispredict_o, .spec_pending_o);

// ### verif/cond_unit_model.sv
// Condition unit model resolving tracked branches after a chosen delay
`timescale 1ns/1ps
module cond_unit_model
	import bp_pkg::*;
(
	// Clock
	input wire logic core_clk_i,
	// Resolve result
	output logic res_valid_o,
	output logic [SLOT_W-1:0] res_tag_o,
	output logic res_taken_o
);
	// Idle state at time zero
	initial begin
		res_valid_o = 1'b0;
		res_tag_o = 3'h0;
		res_taken_o = 1'b0;
	end
	// One-cycle result; idle lines invert so stale values never match
	task automatic resolve(input logic [SLOT_W-1:0] tag, input logic taken, input int delay);
		repeat (delay) @(negedge core_clk_i);
		@(negedge core_clk_i);
		res_valid_o = 1'b1;
		res_tag_o = tag;
		res_taken_o = taken;
		@(negedge core_clk_i);
		res_valid_o = 1'b0;
		res_tag_o = ~tag;
		res_taken_o = ~taken;
	endtask
endmodule

// ### verif/branch_prediction_resolution_test.sv
// Self-checking bench for the branch prediction and resolution block
`timescale 1ns/1ps
module branch_prediction_resolution_test import bp_pkg::*;;
	logic core_clk_i, srst_i, dec_valid_i, btc_fill_i, res_valid_i, res_taken_i, ibuf_flush_o, ibuf_load_o;
	br_kind_t dec_kind_i;
	logic [ADDR_W-1:0] dec_pc_i, dec_disp0_i, dec_disp1_i, btc_fill_addr_i, fetch_target_o;
	logic [LEN_W-1:0] dec_len_i;
	logic [CAND_SEL_W-1:0] dec_sel_i;
	logic [LINE_W-1:0] btc_fill_data_i, ibuf_data_o;
	logic [SLOT_W-1:0] res_tag_i, branch_tag_o, recover_tag_o;
	logic fetch_redirect_o, branch_stall_o, branch_tag_vld_o, pred_taken_o, mispredict_o, spec_pending_o;
	int error_cnt, cmp_count;
	branch_prediction_resolution u_branch_prediction_resolution (.core_clk_i, .srst_i, .dec_valid_i, .dec_kind_i,
		.dec_pc_i, .dec_len_i, .dec_disp0_i, .dec_disp1_i, .dec_sel_i, .btc_fill_i, .btc_fill_addr_i,
		.btc_fill_data_i, .res_valid_i, .res_tag_i, .res_taken_i, .fetch_redirect_o, .fetch_target_o, .ibuf_flush_o,
		.ibuf_load_o, .ibuf_data_o, .branch_stall_o, .branch_tag_vld_o, .branch_tag_o, .pred_taken_o,
		.mispredict_o, .recover_tag_o, .spec_pending_o);
	cond_unit_model u_cond_unit_model (.core_clk_i, .res_valid_o(res_valid_i), .res_tag_o(res_tag_i),
		.res_taken_o(res_taken_i));
	// Free-running core clock
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic check(input logic [LINE_W-1:0] seen, input logic [LINE_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// One decode report, lowered again before the next edge so it is taken once
	task automatic dec(input br_kind_t k, input logic [ADDR_W-1:0] pc, input logic [LEN_W-1:0] len,
		input logic [ADDR_W-1:0] d0, input logic s);
		@(negedge core_clk_i);
		dec_valid_i = 1'b1;
		dec_kind_i = k;
		dec_pc_i = pc;
		dec_len_i = len;
		dec_disp0_i = d0;
		dec_disp1_i = ~d0;
		dec_sel_i = s;
		@(negedge core_clk_i);
		dec_valid_i = 1'b0;
	endtask
	// Bounded wait until no branch is tracked and issue is open
	task automatic wait_idle(input int lim);
		int n;
		n = 0;
		while (spec_pending_o !== 1'b0 || branch_stall_o !== 1'b0) begin
			@(negedge core_clk_i);
			n++;
			if (n > lim) begin
				error_cnt++;
				complete_run();
			end
		end
	endtask
	task automatic s_jump();
		for (int s = 0; s < 2; s++) begin
			dec(KIND_JUMP, 32'h100, 4'h2, 32'h40, s[0]);
			check(fetch_redirect_o, 1'b1);
			check(ibuf_flush_o, 1'b1);
			check(ibuf_load_o, 1'b0);
			check(fetch_target_o, s ? 32'hC1 : 32'h142);
		end
		dec(KIND_NONE, 32'h200, 4'h1, 32'h40, 1'b0);
		check(fetch_redirect_o, 1'b0);
	endtask
	// Seventeen fills: the last evicts the first line round robin
	task automatic s_btc();
		for (int i = 0; i < 17; i++) begin
			@(negedge core_clk_i);
			btc_fill_i = 1'b1;
			btc_fill_addr_i = 32'h1000 + 32'(i * 16);
			btc_fill_data_i = {16{8'(i + 8'h5A)}};
		end
		@(negedge core_clk_i);
		btc_fill_i = 1'b0;
		dec(KIND_JUMP, 32'h0, 4'h0, 32'h1100, 1'b0);
		check(ibuf_load_o, 1'b1);
		check(ibuf_data_o, {16{8'h6A}});
		dec(KIND_JUMP, 32'h0, 4'h0, 32'h1010, 1'b0);
		check(ibuf_data_o, {16{8'h5B}});
		dec(KIND_JUMP, 32'h0, 4'h0, 32'h1000, 1'b0);
		check(ibuf_load_o, 1'b0);
	endtask
	// Empty pop, then one push beyond depth so the oldest is lost
	task automatic s_ret();
		dec(KIND_RET, 32'h500, 4'h1, 32'h0, 1'b0);
		check(fetch_redirect_o, 1'b0);
		for (int i = 0; i < 17; i++) begin
			dec(KIND_CALL, 32'h400 + 32'(i * 16), 4'h3, 32'h80, 1'b0);
		end
		check(fetch_target_o, 32'h583);
		for (int i = 16; i > 0; i--) begin
			dec(KIND_RET, 32'h600, 4'h1, 32'h0, 1'b0);
			check(fetch_target_o, 32'h403 + 32'(i * 16));
		end
		dec(KIND_RET, 32'h600, 4'h1, 32'h0, 1'b0);
		check(fetch_redirect_o, 1'b0);
	endtask
	task automatic s_cond();
		logic [SLOT_W-1:0] t;
		dec(KIND_COND, 32'h2000, 4'h2, 32'h20, 1'b0);
		t = branch_tag_o;
		check(t, 3'h0);
		check(branch_tag_vld_o, 1'b1);
		check(pred_taken_o, 1'b0);
		check(fetch_redirect_o, 1'b0);
		check(spec_pending_o, 1'b1);
		u_cond_unit_model.resolve(t, 1'b1, 3);
		check(mispredict_o, 1'b1);
		check(recover_tag_o, t);
		check(fetch_target_o, 32'h2022);
		wait_idle(40);
		check(spec_pending_o, 1'b0);
	endtask
	// Seven in flight stall the eighth; recovery at the oldest frees all
	task automatic s_full();
		logic [SLOT_W-1:0] t0;
		logic p0;
		for (int i = 0; i < 7; i++) begin
			dec(KIND_COND, 32'h3000 + 32'(i * 4), 4'h2, 32'h100, 1'b0);
			check(branch_tag_vld_o, 1'b1);
			if (i == 0) begin
				t0 = branch_tag_o;
				p0 = pred_taken_o;
			end
		end
		check(branch_stall_o, 1'b1);
		dec(KIND_COND, 32'h3100, 4'h2, 32'h100, 1'b0);
		check(branch_tag_vld_o, 1'b0);
		u_cond_unit_model.resolve(t0, ~p0, 0);
		check(mispredict_o, 1'b1);
		u_cond_unit_model.resolve(t0 + 3'h1, 1'b1, 0);
		check(mispredict_o, 1'b0);
		wait_idle(40);
		check(branch_stall_o, 1'b0);
	endtask
	// Counter trained by the earlier resolve predicts taken; guessed target hits the cache
	task automatic s_taken();
		dec(KIND_COND, 32'h4003, 4'h2, 32'hFFFFD01B, 1'b0);
		check(pred_taken_o, 1'b1);
		check(fetch_redirect_o, 1'b1);
		check(fetch_target_o, 32'h1020);
		check(ibuf_load_o, 1'b1);
		check(ibuf_data_o, {16{8'h5C}});
		u_cond_unit_model.resolve(branch_tag_o, 1'b0, 1);
		check(mispredict_o, 1'b1);
		check(fetch_target_o, 32'h4005);
		wait_idle(40);
		check(spec_pending_o, 1'b0);
	endtask
	// Main sequence: reset, table sweep, then each scenario
	initial begin
		error_cnt = 0;
		cmp_count = 0;
		srst_i = 1'b1;
		dec_valid_i = 1'b0;
		dec_kind_i = KIND_NONE;
		dec_pc_i = 32'h0;
		dec_len_i = 4'h0;
		dec_disp0_i = 32'h0;
		dec_disp1_i = 32'h0;
		dec_sel_i = 1'b0;
		btc_fill_i = 1'b0;
		btc_fill_addr_i = 32'h0;
		btc_fill_data_i = 128'h0;
		repeat (3) @(negedge core_clk_i);
		check(branch_stall_o, 1'b1);
		srst_i = 1'b0;
		wait_idle(9000);
		s_jump();
		s_btc();
		s_ret();
		s_cond();
		s_full();
		s_taken();
		complete_run();
	end
endmodule
